// ==== logic/wsc_wakeup_controller.v ====
// wake-up source controller for the low-power wait state
// Overview of operation
// - source bits 7:6 pick slow oscillator rate
// - bit 4 wakes on low serial-select
// - bit 3 wakes on low interrupt input
// - bit 1 wakes on tag detected
// - bit 0 wakes at timeout, back to ready
// - timeout = max sleep * (period+1) * unit
// - time unit is 256 oscillator periods
// - idle command loads source register
// - cause register updated on leaving wait
// - cause readable by read and idle reply
`timescale 1ns/10ps
`include "wsc_regs.vh"
module wsc_wakeup_controller #(
   parameter DIV_32K = `WSC_OSC_DIV_32K
) (
   clk_sys,
   resetn,
   idleStart,
   idleSource,
   maxSleepCount,
   wakePeriodValue,
   regReadReq,
   regReadSel,
   selectPinN,
   irqInPinN,
   tagDetected,
   waitActive,
   idleDone,
   idleReply,
   regReadValid,
   regReadData,
   oscRun
);
   input              clk_sys;
   input              resetn;
   input              idleStart;
   input  [7:0]       idleSource;
   input  [4:0]       maxSleepCount;
   input  [7:0]       wakePeriodValue;
   input              regReadReq;
   input              regReadSel;
   input              selectPinN;
   input              irqInPinN;
   input              tagDetected;
   output reg         waitActive;
   output reg         idleDone;
   output reg [7:0]   idleReply;
   output reg         regReadValid;
   output reg [7:0]   regReadData;
   output reg         oscRun;

   // two states: ready, and waiting for a wake event
   localparam ST_READY = 1'b0;
   localparam ST_WAIT  = 1'b1;

   // ==========================================================
   // pin synchronisers
   // reset to the idle high level so no false wake follows reset
   reg [1:0] selSync_reg;
   reg [1:0] irqSync_reg;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         selSync_reg <= 2'b11;
         irqSync_reg <= 2'b11;
      end else begin
         selSync_reg <= {selSync_reg[0], selectPinN};
         irqSync_reg <= {irqSync_reg[0], irqInPinN};
      end
   end
   wire selLow = ~selSync_reg[1];
   wire irqLow = ~irqSync_reg[1];

   // ==========================================================
   // state and registers
   reg        state_reg;
   reg [7:0]  wakeSourceConfig_reg;
   reg [7:0]  wakeCauseRecord_reg;
   reg [7:0]  refCnt_reg;
   // 13 bits hold the largest legal product of sleeps and periods
   reg [12:0] unitCnt_reg;
   reg [12:0] timeoutUnits_reg;
   wire       oscTick;

   // ==========================================================
   // slow oscillator
   // it only runs while waiting, which is where the power is saved
   wire       waitRun = (state_reg == ST_WAIT);
   wire [1:0] rateSel = wakeSourceConfig_reg[`WSC_RATE_HI:`WSC_RATE_LO];

   wsc_rate_divider #(
      .DIV_32K (DIV_32K)
   ) uRate (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .rateSel (rateSel),
      .run     (waitRun),
      .oscTick (oscTick)
   );

   // timeout length in reference units
   function [12:0] toUnits;
      input [4:0] sleeps;
      input [7:0] period;
      begin
         toUnits = sleeps * ({1'b0, period} + 9'h001);
      end
   endfunction

   // ==========================================================
   // wake decode
   // a compare, not an equality, so a saturated count still wakes
   wire timeoutHit = (unitCnt_reg >= timeoutUnits_reg);

   // one-hot cause, highest listed source first when several coincide
   reg [7:0] cause;
   always @* begin
      cause = 8'h00;
      if (wakeSourceConfig_reg[`WSC_BIT_SELECT] && selLow) begin
         cause[`WSC_BIT_SELECT] = 1'b1;
      end else if (wakeSourceConfig_reg[`WSC_BIT_IRQIN] && irqLow) begin
         cause[`WSC_BIT_IRQIN] = 1'b1;
      end else if (wakeSourceConfig_reg[`WSC_BIT_TAG] && tagDetected) begin
         cause[`WSC_BIT_TAG] = 1'b1;
      end else if (wakeSourceConfig_reg[`WSC_BIT_TIMEOUT] && timeoutHit) begin
         cause[`WSC_BIT_TIMEOUT] = 1'b1;
      end
   end

   // ==========================================================
   // reference unit and timeout counting
   wire waitEntry  = (state_reg == ST_READY) && idleStart;
   wire refUnitEnd = oscTick && (refCnt_reg == `WSC_REF_PERIODS - 1);

   // counters clear on entry so each wait is timed from its own start
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         refCnt_reg  <= 8'h00;
         unitCnt_reg <= 13'h0000;
      end else if (waitEntry) begin
         refCnt_reg  <= 8'h00;
         unitCnt_reg <= 13'h0000;
      end else if (waitRun) begin
         if (oscTick) begin
            refCnt_reg <= refCnt_reg + 8'h01;
         end
         // saturate so an overlong wait cannot wrap back under the limit
         if (refUnitEnd && (unitCnt_reg != 13'h1fff)) begin
            unitCnt_reg <= unitCnt_reg + 13'h0001;
         end
      end
   end

   // ==========================================================
   // wait-state sequencing
   // an idle command that arrives while waiting is dropped unanswered
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg            <= ST_READY;
         wakeSourceConfig_reg <= `WSC_SOURCE_RESET;
         wakeCauseRecord_reg  <= `WSC_CAUSE_RESET;
         timeoutUnits_reg     <= 13'h0000;
         waitActive           <= 1'b0;
         idleDone             <= 1'b0;
         idleReply            <= 8'h00;
         oscRun               <= 1'b0;
      end else begin
         idleDone <= 1'b0;
         case (state_reg)
            ST_READY: begin
               if (idleStart) begin
                  // reserved bits kept as zero so reads stay clean
                  wakeSourceConfig_reg <= idleSource & ~`WSC_RESERVED_MASK;
                  // product latched once; later parameter changes do not move it
                  timeoutUnits_reg     <= toUnits(maxSleepCount, wakePeriodValue);
                  state_reg            <= ST_WAIT;
                  waitActive           <= 1'b1;
                  oscRun               <= 1'b1;
               end
            end
            ST_WAIT: begin
               if (cause != 8'h00) begin
                  // cause and reply are written together so both reads agree
                  wakeCauseRecord_reg <= cause;
                  idleReply           <= cause;
                  idleDone            <= 1'b1;
                  state_reg           <= ST_READY;
                  waitActive          <= 1'b0;
                  oscRun              <= 1'b0;
               end
            end
            default: begin
               // unreachable with two states; kept for safe recovery
               state_reg <= ST_READY;
            end
         endcase
      end
   end

   // ==========================================================
   // register-read command
   // selection is combinational, the answer is registered on the request edge
   wire [7:0] readMux = (regReadSel == `WSC_SEL_CAUSE) ?
                        wakeCauseRecord_reg : wakeSourceConfig_reg;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         regReadValid <= 1'b0;
         regReadData  <= 8'h00;
      end else begin
         regReadValid <= regReadReq;
         if (regReadReq) begin
            regReadData <= readMux;
         end
      end
   end
endmodule // wsc_wakeup_controller

// ==== pkg/wsc_regs.vh ====
// constants for the wake-up source controller
`ifndef WSC_REGS_VH
`define WSC_REGS_VH
// ==========================================================
// wake source / cause field positions
`define WSC_RATE_HI        7
`define WSC_RATE_LO        6
`define WSC_BIT_SELECT     4
`define WSC_BIT_IRQIN      3
`define WSC_BIT_TAG        1
`define WSC_BIT_TIMEOUT    0
`define WSC_RESERVED_MASK  8'h24
`define WSC_SOURCE_RESET   8'h08
`define WSC_CAUSE_RESET    8'h00
// ==========================================================
// timing
`define WSC_CLK_HZ         50000000
`define WSC_OSC_HZ_32K     32000
`define WSC_OSC_DIV_32K    (`WSC_CLK_HZ / `WSC_OSC_HZ_32K)
`define WSC_REF_PERIODS    256
// ==========================================================
// register-read selectors
`define WSC_SEL_SOURCE     1'b0
`define WSC_SEL_CAUSE      1'b1
`endif

// ==== logic/wsc_rate_divider.v ====
// slow oscillator tick generator with selectable rate
`timescale 1ns/10ps
`include "wsc_regs.vh"
module wsc_rate_divider #(
   parameter DIV_32K = `WSC_OSC_DIV_32K
) (
   clk_sys,
   resetn,
   rateSel,
   run,
   oscTick
);
   input              clk_sys;
   input              resetn;
   input  [1:0]       rateSel;
   input              run;
   output reg         oscTick;

   // ==========================================================
   // base 32 kHz tick then power-of-two prescale
   reg [15:0] baseCnt_reg;
   reg [2:0]  preCnt_reg;
   wire       baseTick = (baseCnt_reg == DIV_32K - 1);
   wire [2:0] preMask = (3'b001 << rateSel) - 3'b001;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         baseCnt_reg <= 16'h0000;
         preCnt_reg  <= 3'h0;
         oscTick     <= 1'b0;
      end else if (!run) begin
         baseCnt_reg <= 16'h0000;
         preCnt_reg  <= 3'h0;
         oscTick     <= 1'b0;
      end else begin
         oscTick <= 1'b0;
         if (baseTick) begin
            baseCnt_reg <= 16'h0000;
            if ((preCnt_reg & preMask) == preMask) begin
               preCnt_reg <= 3'h0;
               oscTick    <= 1'b1;
            end else begin
               preCnt_reg <= preCnt_reg + 3'h1;
            end
         end else begin
            baseCnt_reg <= baseCnt_reg + 16'h0001;
         end
      end
   end
endmodule // wsc_rate_divider

// ==== verification/wsc_chk_sva.sv ====
// concurrent checks on the wake-up source controller ports
`timescale 1ns/10ps
module wsc_chk (
   input logic       clk_sys,
   input logic       resetn,
   input logic       idleStart,
   input logic [7:0] idleSource,
   input logic       regReadReq,
   input logic       regReadSel,
   input logic       selectPinN,
   input logic       irqInPinN,
   input logic       tagDetected,
   input logic       waitActive,
   input logic       idleDone,
   input logic [7:0] idleReply,
   input logic       regReadValid,
   input logic [7:0] regReadData,
   input logic       oscRun
);
   // ==========================================================
   // copies of loaded source and last cause
   logic [7:0] src_reg;
   logic [7:0] cause_reg;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         src_reg   <= 8'h00;
         cause_reg <= 8'h00;
      end else begin
         if (idleStart && !waitActive) src_reg <= idleSource;
         if (idleDone) cause_reg <= idleReply;
      end
   end
   // ==========================================================
   // properties; pins pass a 2-stage sync, so allow the slack
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_irqLow; (waitActive && src_reg[3] && !irqInPinN)[*3]; endsequence
   sequence s_selLow; (waitActive && src_reg[4] && !selectPinN)[*3]; endsequence
   property p_enter; idleStart && !waitActive |=> waitActive; endproperty
   property p_exit; idleDone |-> !waitActive && $past(waitActive); endproperty
   property p_one; idleDone |-> $onehot(idleReply & 8'h1b); endproperty
   property p_src; idleDone |-> (idleReply & ~src_reg) == 8'h00; endproperty
   property p_tag; waitActive && src_reg[1] && tagDetected |=> idleDone; endproperty
   property p_irq; s_irqLow |-> ##[0:2] idleDone; endproperty
   property p_sel; s_selLow |-> ##[0:2] idleDone; endproperty
   property p_rd; regReadReq |=> regReadValid; endproperty
   property p_rdc; regReadReq && regReadSel && !idleDone |=> regReadData == cause_reg; endproperty
   property p_osc; oscRun == waitActive; endproperty
   a_enter: assert property (p_enter) else $error("wait not entered");
   a_exit: assert property (p_exit) else $error("done outside wait");
   a_one: assert property (p_one) else $error("cause not one-hot");
   a_src: assert property (p_src) else $error("cause not enabled");
   a_tag: assert property (p_tag) else $error("tag wake missed");
   a_irq: assert property (p_irq) else $error("irq wake missed");
   a_sel: assert property (p_sel) else $error("select wake missed");
   a_rd: assert property (p_rd) else $error("read not answered");
   a_rdc: assert property (p_rdc) else $error("cause read wrong");
   a_osc: assert property (p_osc) else $error("oscillator run wrong");
endmodule // wsc_chk

// ==== verification/wsc_host_model.sv ====
// host model issuing idle commands and register reads
`timescale 1ns/10ps
module wsc_host_model (
   input  logic       clk_sys,
   input  logic       idleDone,
   input  logic [7:0] idleReply,
   input  logic       regReadValid,
   input  logic [7:0] regReadData,
   output logic       idleStart,
   output logic [7:0] idleSource,
   output logic [4:0] maxSleepCount,
   output logic [7:0] wakePeriodValue,
   output logic       regReadReq,
   output logic       regReadSel
);
   // ==========================================================
   // command tasks
   initial begin
      {idleStart, idleSource, maxSleepCount, wakePeriodValue} = 22'h0;
      {regReadReq, regReadSel} = 2'b00;
   end
   task automatic idle(input logic [7:0] s, input logic [4:0] m, input logic [7:0] p,
                       output logic [7:0] rep, output int n);
      n = 0;
      @(negedge clk_sys);
      idleSource = s & 8'hdb;
      maxSleepCount = m;
      wakePeriodValue = p;
      idleStart = 1'b1;
      @(negedge clk_sys);
      idleStart = 1'b0;
      // bounded so a dead wake path cannot hang the host
      while (!idleDone && n < 20000) begin
         @(negedge clk_sys);
         n++;
      end
      rep = idleReply;
   endtask
   task automatic rd(input logic sel, output logic v, output logic [7:0] d);
      @(negedge clk_sys);
      regReadSel = sel;
      regReadReq = 1'b1;
      @(negedge clk_sys);
      regReadReq = 1'b0;
      v = regReadValid;
      d = regReadData;
   endtask
endmodule // wsc_host_model

// ==== verification/tb.sv ====
// self-checking testbench for the wake-up source controller
`timescale 1ns/10ps
module tb;
   logic       clk_sys = 1'b0;
   logic       resetn = 1'b0;
   logic       selectPinN = 1'b1;
   logic       irqInPinN = 1'b1;
   logic       tagDetected = 1'b0;
   logic       idleStart, regReadReq, regReadSel, waitActive, idleDone, regReadValid, oscRun, v0;
   logic [7:0] idleSource, wakePeriodValue, idleReply, regReadData, d0;
   logic [4:0] maxSleepCount;
   int         miscompares = 0;
   int         check_count = 0;
   always #10 clk_sys = ~clk_sys;
   // short slow tick keeps the timeout runs brief
   wsc_wakeup_controller #(.DIV_32K(4)) dut (.*);
   wsc_host_model host (.*);
   // ==========================================================
   // checking and run control
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ev: bit4 select low, bit3 irq low, bit1 tag, applied once waiting
   task automatic run(input logic [7:0] s, input logic [4:0] m, input logic [7:0] p,
                      input logic [7:0] ev, input logic [7:0] ex, input int t);
      logic [7:0] rep, d;
      logic       v;
      int         n;
      fork
         host.idle(s, m, p, rep, n);
         begin
            repeat (4) @(negedge clk_sys);
            selectPinN = !ev[4];
            irqInPinN = !ev[3];
            tagDetected = ev[1];
            chk("osc run", 16'h1, {15'h0, oscRun});
         end
      join
      {selectPinN, irqInPinN, tagDetected} = 3'b110;
      chk("osc stop", 16'h0, {15'h0, oscRun});
      chk("cause", {8'h0, ex}, {8'h0, rep});
      chk("time", 16'h1, {15'h0, n >= t - 40 && n <= t + 40});
      host.rd(1'b1, v, d);
      chk("read cause", {8'h01, ex}, {7'h0, v, d});
      host.rd(1'b0, v, d);
      chk("read source", {8'h01, s}, {7'h0, v, d});
   endtask
   initial begin
      #1000000;
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (8) @(negedge clk_sys);
      resetn = 1'b1;
      host.rd(1'b0, v0, d0);
      chk("reset source", 16'h0108, {7'h0, v0, d0});
      host.rd(1'b1, v0, d0);
      chk("reset cause", 16'h0100, {7'h0, v0, d0});
      for (int r = 0; r < 4; r++)
         run({r[1:0], 6'h09}, 5'd1, 8'h00, 8'h00, 8'h01, 1024 << r);
      run(8'h01, 5'd2, 8'h01, 8'h1a, 8'h01, 4096);
      run(8'h0b, 5'd30, 8'hff, 8'h02, 8'h02, 4);
      run(8'h09, 5'd30, 8'hff, 8'h08, 8'h08, 4);
      run(8'h11, 5'd30, 8'hff, 8'h10, 8'h10, 4);
      run(8'h19, 5'd30, 8'hff, 8'h18, 8'h10, 4);
      stop_test();
   end
endmodule // tb
bind wsc_wakeup_controller wsc_chk u_chk (.*);
